// ---- hdl/ccfc_checker.sv ----
/*
 * Cyclic command area checker: collects each received frame, checks the
 * station address, command/response flag, sub-check flag and cyclic command
 * code, raises two sticky alarms and keeps the last good frame.
 * Assumes frame bytes, link status and the threshold come from logic on
 * ref_clk_i; the rotary switch is an asynchronous pin.
 */
`timescale 1ns/1ps
`include "ccfc_params.svh"

module ccfc_checker #(
    parameter logic [7:0]  DEFINED_CMDS  = `CCFC_DEFINED_CMDS,
    parameter logic [15:0] SUB_CHK_CODE  = `CCFC_CODE_NONE
) (
    // Clock, reset, enable
    input  wire logic                    ref_clk_i,
    input  wire logic                    resetn_i,
    input  wire logic                    ce_i,
    // Link controller status
    input  wire logic                    link_state_a_i,
    input  wire logic                    sync_ok_i,
    input  wire logic                    frame_mode_long_i,
    // Received frame bytes
    input  wire logic                    byte_valid_i,
    input  wire logic                    frame_start_i,
    input  wire logic                    frame_end_i,
    input  wire logic [7:0]              byte_i,
    // Configuration and pins
    input  wire logic [4:0]              station_switch_i,
    input  wire logic [4:0]              consecutive_error_threshold_i,
    input  wire logic                    alarm_clear_i,
    // Held frame read port
    input  wire logic [`CCFC_RD_W-1:0]   rd_addr_i,
    output logic      [7:0]              rd_data_o,
    output logic                         held_valid_o,
    // Alarms and status
    output logic                         cyclic_data_alarm_first_o,
    output logic                         cyclic_data_alarm_second_o,
    output logic      [15:0]             error_code_o,
    output logic                         frame_good_o,
    output logic                         frame_discard_o,
    output logic      [4:0]              sub_err_count_o
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    ccfc_pkg::ccfc_rx_state_t state;
    ccfc_pkg::ccfc_rx_state_t next_state;

    ccfc_pkg::ccfc_byte_t rx_buf [0:31];
    ccfc_pkg::ccfc_byte_t held   [0:31];

    logic [`CCFC_IDX_W-1:0] rx_cnt;
    logic [4:0]             switch_meta;
    logic [4:0]             switch_addr;

    logic       len_ok;
    logic       eval;
    logic       addr_err;
    logic       cr_err;
    logic       cmd_err;
    logic       sub_err;
    logic       frame_bad;
    logic       accept;
    logic       run_step;
    logic       run_clear;
    logic       run_reached;
    logic       first_hit;
    logic       second_hit;
    logic [2:0] cmd_code;

    // ****************************************************************
    // Rotary switch synchroniser
    // ****************************************************************
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            switch_meta <= 5'h00;
            switch_addr <= 5'h00;
        end
        else if (ce_i)
        begin
            switch_meta <= station_switch_i;
            switch_addr <= switch_meta;
        end
    end

    // ****************************************************************
    // Receive sequencer
    // ****************************************************************
    always_comb
    begin
        next_state = state;
        case (state)
            ccfc_pkg::CCFC_WAIT:
                if (byte_valid_i && frame_start_i)
                    next_state = frame_end_i ? ccfc_pkg::CCFC_CHECK : ccfc_pkg::CCFC_RECV;
            ccfc_pkg::CCFC_RECV:
                if (frame_end_i)
                    next_state = ccfc_pkg::CCFC_CHECK;
            ccfc_pkg::CCFC_CHECK:
                next_state = ccfc_pkg::CCFC_WAIT;
            default:
                next_state = ccfc_pkg::CCFC_WAIT;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            state <= ccfc_pkg::CCFC_WAIT;
        else if (ce_i)
            state <= next_state;
    end

    // Byte capture; bytes past the long length are dropped
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rx_cnt <= '0;
        else if (ce_i && byte_valid_i)
        begin
            if (frame_start_i && state == ccfc_pkg::CCFC_WAIT)
                rx_cnt <= `CCFC_IDX_W'(1);
            else if (state == ccfc_pkg::CCFC_RECV && rx_cnt < `CCFC_LONG_BYTES)
                rx_cnt <= `CCFC_IDX_W'(rx_cnt + 1'b1);
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            for (int i = 0; i < 32; i++)
                rx_buf[i] <= 8'h00;
        end
        else if (ce_i && byte_valid_i)
        begin
            if (frame_start_i && state == ccfc_pkg::CCFC_WAIT)
                rx_buf[0] <= byte_i;
            else if (state == ccfc_pkg::CCFC_RECV && rx_cnt < `CCFC_LONG_BYTES)
                rx_buf[rx_cnt[`CCFC_RD_W-1:0]] <= byte_i;
        end
    end

    // ****************************************************************
    // Field checks
    // ****************************************************************
    function automatic logic cmd_defined(input logic [2:0] code, input logic [7:0] mask);
        cmd_defined = mask[code];
    endfunction : cmd_defined

    assign len_ok   = rx_cnt >= (frame_mode_long_i ? `CCFC_LONG_BYTES : `CCFC_SHORT_BYTES);
    assign eval     = (state == ccfc_pkg::CCFC_CHECK) && link_state_a_i && sync_ok_i && len_ok;
    assign cmd_code = rx_buf[`CCFC_CMD_BYTE][`CCFC_CMD_MSB:`CCFC_CMD_LSB];

    assign addr_err = rx_buf[`CCFC_ADDR_BYTE][`CCFC_ADDR_MSB:`CCFC_ADDR_LSB] != switch_addr;
    assign cr_err   = rx_buf[`CCFC_CR_BYTE][`CCFC_CR_BIT];
    assign cmd_err  = !cmd_defined(cmd_code, DEFINED_CMDS);
    assign sub_err  = frame_mode_long_i && !rx_buf[`CCFC_SUB_BYTE][`CCFC_SUB_BIT];

    assign frame_bad = addr_err || cr_err || cmd_err || sub_err;
    assign accept    = eval && !frame_bad;

    assign run_step  = eval && sub_err;
    assign run_clear = eval && !sub_err;

    ccfc_run_counter #(
        .CNT_W       (5)
    ) u_run_counter (
        .ref_clk_i   (ref_clk_i),
        .resetn_i    (resetn_i),
        .ce_i        (ce_i),
        .clear_i     (run_clear),
        .step_i      (run_step),
        .threshold_i (consecutive_error_threshold_i),
        .count_o     (sub_err_count_o),
        .reached_o   (run_reached)
    );

    assign first_hit  = eval && (addr_err || cr_err || run_reached);
    assign second_hit = eval && cmd_err;

    // ****************************************************************
    // Alarms: a new fault wins over a clear in the same cycle
    // ****************************************************************
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cyclic_data_alarm_first_o  <= 1'b0;
            cyclic_data_alarm_second_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (first_hit)
                cyclic_data_alarm_first_o <= 1'b1;
            else if (alarm_clear_i)
                cyclic_data_alarm_first_o <= 1'b0;
            if (second_hit)
                cyclic_data_alarm_second_o <= 1'b1;
            else if (alarm_clear_i)
                cyclic_data_alarm_second_o <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            error_code_o <= `CCFC_CODE_NONE;
        else if (ce_i)
        begin
            if (eval && addr_err)
                error_code_o <= `CCFC_CODE_ADDR;
            else if (eval && cr_err)
                error_code_o <= `CCFC_CODE_CR;
            else if (eval && run_reached)
                error_code_o <= SUB_CHK_CODE;
            else if (second_hit)
                error_code_o <= `CCFC_CODE_CMD;
            else if (alarm_clear_i)
                error_code_o <= `CCFC_CODE_NONE;
        end
    end

    // ****************************************************************
    // Frame acceptance and held data
    // ****************************************************************
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            frame_good_o    <= 1'b0;
            frame_discard_o <= 1'b0;
            held_valid_o    <= 1'b0;
        end
        else if (ce_i)
        begin
            frame_good_o    <= accept;
            frame_discard_o <= (state == ccfc_pkg::CCFC_CHECK) && !accept;
            if (accept)
                held_valid_o <= 1'b1;
        end
    end

    // Only good frames overwrite the held copy
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            for (int i = 0; i < 32; i++)
                held[i] <= 8'h00;
        end
        else if (ce_i && accept)
        begin
            for (int i = 0; i < 32; i++)
                held[i] <= rx_buf[i];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rd_data_o <= 8'h00;
        else if (ce_i)
            rd_data_o <= held[rd_addr_i];
    end

endmodule : ccfc_checker

// ---- hdl/ccfc_params.svh ----
/*
 * Named constants of the cyclic frame field checker: byte and bit positions
 * of the checked fields, frame lengths, threshold limits and error codes.
 * Assumes nothing; definitions only, included by bare name.
 */
`ifndef CCFC_PARAMS_SVH
`define CCFC_PARAMS_SVH

// ****************************************************************
// Frame geometry
// ****************************************************************
`define CCFC_LONG_BYTES      6'h20
`define CCFC_SHORT_BYTES     6'h10
`define CCFC_IDX_W           6
`define CCFC_RD_W            5

// ****************************************************************
// Field positions
// ****************************************************************
`define CCFC_ADDR_BYTE       0
`define CCFC_ADDR_MSB        4
`define CCFC_ADDR_LSB        0
`define CCFC_CR_BYTE         0
`define CCFC_CR_BIT          7
`define CCFC_CMD_BYTE        1
`define CCFC_CMD_MSB         6
`define CCFC_CMD_LSB         4
`define CCFC_SUB_BYTE        16
`define CCFC_SUB_BIT         7

// ****************************************************************
// Threshold limits and defaults
// ****************************************************************
`define CCFC_TH_MIN          5'h02
`define CCFC_TH_MAX          5'h11
`define CCFC_DEFINED_CMDS    8'h3f

// ****************************************************************
// Error codes
// ****************************************************************
`define CCFC_CODE_NONE       16'h0000
`define CCFC_CODE_ADDR       16'h0011
`define CCFC_CODE_CR         16'h0012
`define CCFC_CODE_CMD        16'h0021

`endif

// ---- hdl/ccfc_pkg.sv ----
/*
 * Types of the cyclic frame field checker.
 * Assumes the constants header is available to the design files.
 */
package ccfc_pkg;

    // ****************************************************************
    // Receive sequencer states
    // ****************************************************************
    typedef enum logic [1:0]
    {
        CCFC_WAIT,
        CCFC_RECV,
        CCFC_CHECK
    } ccfc_rx_state_t;

    typedef logic [7:0] ccfc_byte_t;

endpackage : ccfc_pkg

// ---- hdl/ccfc_run_counter.sv ----
/*
 * Counter of uninterrupted sub-check errors with a clamped threshold.
 * Assumes step and clear come from logic on the same clock, never together.
 */
`timescale 1ns/1ps
`include "ccfc_params.svh"

module ccfc_run_counter #(
    parameter int CNT_W = 5
) (
    // Clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             resetn_i,
    input  wire logic             ce_i,
    // Control
    input  wire logic             clear_i,
    input  wire logic             step_i,
    input  wire logic [CNT_W-1:0] threshold_i,
    // Status
    output logic      [CNT_W-1:0] count_o,
    output logic                  reached_o
);

    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] eff_threshold;

    // Clamp threshold into the legal, effective range
    function automatic logic [CNT_W-1:0] clamp_threshold(input logic [CNT_W-1:0] th);
        if (th < CNT_W'(`CCFC_TH_MIN))
            clamp_threshold = CNT_W'(`CCFC_TH_MIN);
        else if (th > CNT_W'(`CCFC_TH_MAX))
            clamp_threshold = CNT_W'(`CCFC_TH_MAX);
        else
            clamp_threshold = th;
    endfunction : clamp_threshold

    assign eff_threshold = clamp_threshold(threshold_i);
    assign next_count    = (&count_o) ? count_o : CNT_W'(count_o + 1'b1);

    // Step that makes the run reach or stay past the threshold
    assign reached_o = step_i && (next_count >= eff_threshold);

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            count_o <= '0;
        else if (ce_i)
        begin
            if (clear_i)
                count_o <= '0;
            else if (step_i)
                count_o <= next_count;
        end
    end

endmodule : ccfc_run_counter

// ---- tb/ccfc_host_model.sv ----
/* Host controller model sending cyclic command frames byte by byte.
   Assumes the bench calls send between frames, one frame at a time. */
`timescale 1ns/1ps
module ccfc_host_model (
    // Clock
    input  wire logic ref_clk_i,
    // Frame stream
    output logic       byte_valid_o = 1'b0,
    output logic       frame_start_o = 1'b0,
    output logic       frame_end_o = 1'b0,
    output logic [7:0] byte_o = 8'h00
);
    task automatic send(input logic [255:0] f, input int n);
        int k;
        for (k = 0; k < n; k++)
        begin
            @(negedge ref_clk_i);
            byte_valid_o = 1'b1;
            frame_start_o = (k == 0);
            frame_end_o = (k == n - 1);
            byte_o = f[k*8 +: 8];
        end
        @(negedge ref_clk_i);
        byte_valid_o = 1'b0;
        frame_start_o = 1'b0;
        frame_end_o = 1'b0;
        // Released line shows the inverse
        byte_o = ~byte_o;
    endtask : send
endmodule : ccfc_host_model

// ---- tb/ccfc_port_checker.sv ----
/* Port assertions of the cyclic frame field checker.
   Assumes one clock and the asynchronous active-low reset. */
`timescale 1ns/1ps
module ccfc_port_checker (
    // Clock and reset
    input wire logic        ref_clk_i,
    input wire logic        resetn_i,
    // Watched ports
    input wire logic        link_state_a_i,
    input wire logic        frame_mode_long_i,
    input wire logic        frame_end_i,
    input wire logic        alarm_clear_i,
    input wire logic [4:0]  rd_addr_i,
    input wire logic [7:0]  rd_data_o,
    input wire logic        held_valid_o,
    input wire logic        cyclic_data_alarm_first_o,
    input wire logic        cyclic_data_alarm_second_o,
    input wire logic [15:0] error_code_o,
    input wire logic        frame_good_o,
    input wire logic        frame_discard_o,
    input wire logic [4:0]  sub_err_count_o
);
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);
    verdict_timing_a: assert property ((frame_good_o || frame_discard_o) |-> $past(frame_end_i, 2))
        else $error("Verdict not two cycles after frame end");
    link_gate_a: assert property ($past(frame_end_i, 2) && !$past(link_state_a_i) |-> !frame_good_o)
        else $error("Frame accepted with link down");
    good_no_alarm_a: assert property (frame_good_o |-> !$rose(cyclic_data_alarm_first_o)
        && !$rose(cyclic_data_alarm_second_o))
        else $error("Alarm raised by a good frame");
    addr_code_a: assert property ($changed(error_code_o) && error_code_o == 16'h0011
        |-> cyclic_data_alarm_first_o)
        else $error("Address code without first alarm");
    count_hold_a: assert property (!(frame_good_o || frame_discard_o) |-> $stable(sub_err_count_o))
        else $error("Run count moved between verdicts");
    alarm_sticky_a: assert property ($fell(cyclic_data_alarm_first_o) || $fell(cyclic_data_alarm_second_o)
        |-> $past(alarm_clear_i))
        else $error("Alarm dropped without clear");
    held_keep_a: assert property (held_valid_o && $past(held_valid_o) && !$past(frame_good_o)
        && $past(rd_addr_i) == $past(rd_addr_i, 2) |-> $stable(rd_data_o))
        else $error("Held frame changed without a good frame");
    sub_clear_a: assert property (frame_good_o && frame_mode_long_i |-> sub_err_count_o == 5'h00)
        else $error("Run count not cleared by good frame");
    cover property (frame_good_o);
    cover property ($rose(cyclic_data_alarm_first_o));
    cover property ($rose(cyclic_data_alarm_second_o));
endmodule : ccfc_port_checker
bind ccfc_checker ccfc_port_checker i_ccfc_port_checker (.ref_clk_i, .resetn_i, .link_state_a_i,
    .frame_mode_long_i, .frame_end_i, .alarm_clear_i, .rd_addr_i, .rd_data_o, .held_valid_o,
    .cyclic_data_alarm_first_o, .cyclic_data_alarm_second_o, .error_code_o, .frame_good_o,
    .frame_discard_o, .sub_err_count_o);

// ---- tb/tb_top.sv ----
/* Self-checking bench of the cyclic frame field checker with a reference model.
   Assumes the host model and the port checker are compiled first. */
`timescale 1ns/1ps
`include "ccfc_params.svh"
module tb_top;
    localparam logic [15:0] SUB = 16'h0013; // Arbitrary sub-check code
    localparam logic [7:0]  DEF = `CCFC_DEFINED_CMDS;
    logic         ref_clk_i = 1'b0;
    logic         resetn_i = 1'b0;
    logic         link = 1'b1, sync = 1'b1, lng = 1'b0, clr = 1'b0, en = 1'b1;
    logic [4:0]   hm = 5'h0f;
    logic [4:0]   sw = 5'h0a, th = 5'h00, rd_addr = 5'h00, cnt;
    logic         bv, fs, fe, good, disc, a1, a2, hv;
    logic [7:0]   bt, rd_data;
    logic [15:0]  code;
    logic [255:0] held = '0;
    logic         e1 = 1'b0, e2 = 1'b0, hv_e = 1'b0;
    logic [15:0]  code_e = 16'h0000;
    int           seed = 57, fails = 0, compares = 0, ce = 0, i;
    int           tv[4] = '{0, 1, 3, 17};
    initial forever #2 ref_clk_i = ~ref_clk_i;
    ccfc_checker #(.SUB_CHK_CODE(SUB)) i_ccfc_checker (
        .ref_clk_i, .resetn_i, .ce_i(en), .link_state_a_i(link), .sync_ok_i(sync),
        .frame_mode_long_i(lng), .byte_valid_i(bv), .frame_start_i(fs), .frame_end_i(fe),
        .byte_i(bt), .station_switch_i(sw), .consecutive_error_threshold_i(th),
        .alarm_clear_i(clr), .rd_addr_i(rd_addr), .rd_data_o(rd_data), .held_valid_o(hv),
        .cyclic_data_alarm_first_o(a1), .cyclic_data_alarm_second_o(a2), .error_code_o(code),
        .frame_good_o(good), .frame_discard_o(disc), .sub_err_count_o(cnt));
    ccfc_host_model i_host (.ref_clk_i, .byte_valid_o(bv), .frame_start_o(fs), .frame_end_o(fe),
        .byte_o(bt));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e)
        begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic final_report();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic clear();
        clr = 1'b1;
        @(negedge ref_clk_i);
        clr = 1'b0;
        e1 = 1'b0;
        e2 = 1'b0;
        code_e = 16'h0000;
        @(negedge ref_clk_i);
        chk(a1 | a2, 1'b0);
        chk(code, code_e);
    endtask : clear
    // One frame through host, reference model and comparison
    task automatic frm(input logic [4:0] ad, input logic cr, input logic [2:0] cm, input logic sb, input int n);
        logic [255:0] f;
        logic         ea, es, eb, ok, al, g;
        int           k, t;
        for (k = 0; k < 8; k++) f[k*32 +: 32] = $random(seed);
        f[4:0] = ad;
        f[7] = cr;
        f[14:12] = cm;
        f[135] = sb;
        ea = (ad != sw);
        eb = !DEF[cm];
        es = lng && !sb;
        ok = link && sync && n >= (lng ? 32 : 16);
        t = (th < 2) ? 2 : (th > 17) ? 17 : th;
        al = 1'b0;
        g = ok && !(ea | cr | es | eb);
        i_host.send(f, n);
        for (k = 0; k < 8 && good !== 1'b1 && disc !== 1'b1; k++) @(negedge ref_clk_i);
        if (ok)
        begin
            if (lng) ce = es ? ce + 1 : 0;
            al = es && ce >= t;
            e1 = e1 | ea | cr | al;
            e2 = e2 | eb;
            if (ea | cr | al | eb) code_e = ea ? 16'h0011 : cr ? 16'h0012 : al ? SUB : 16'h0021;
        end
        if (g) held = f;
        if (g) hv_e = 1'b1;
        // Short held frames only hold their first bytes
        if (g) hm = (n >= 32) ? 5'h1f : 5'h0f;
        chk(good, g);
        chk(disc, !g);
        chk(a1, e1);
        chk(a2, e2);
        chk(code, code_e);
        chk(cnt, ce);
        chk(hv, hv_e);
        rd_addr = $random(seed) & hm;
        @(negedge ref_clk_i);
        if (hv_e) chk(rd_data, held[rd_addr*8 +: 8]);
    endtask : frm
    initial
    begin
        repeat (6) @(negedge ref_clk_i);
        resetn_i = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        for (i = 0; i < 8; i++) frm(sw, 1'b0, i, 1'b1, 16);
        frm(sw ^ 5'h01, 1'b0, 3'h0, 1'b1, 16);
        frm(sw, 1'b1, 3'h1, 1'b1, 16);
        clear();
        lng = 1'b1;
        for (i = 0; i < 4; i++)
        begin
            th = tv[i];
            clear();
            frm(sw, 1'b0, 3'h0, 1'b0, 32);
            frm(sw, 1'b0, 3'h0, 1'b1, 32);
            repeat (tv[i] < 2 ? 2 : tv[i]) frm(sw, 1'b0, 3'h2, 1'b0, 32);
        end
        frm(sw, 1'b0, 3'h0, 1'b1, 20);
        link = 1'b0;
        frm(sw, 1'b1, 3'h7, 1'b0, 32);
        link = 1'b1;
        sync = 1'b0;
        frm(sw ^ 5'h02, 1'b0, 3'h6, 1'b1, 32);
        sync = 1'b1;
        // Frozen enable: a whole frame is ignored, no verdict
        en = 1'b0;
        i_host.send({8{$random(seed)}}, 32);
        @(negedge ref_clk_i);
        chk(good | disc, 1'b0);
        chk(a1, e1);
        chk(cnt, ce);
        en = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        frm(sw, 1'b0, 3'h5, 1'b1, 32);
        final_report();
    end
    initial
    begin
        #200000;
        fails++;
        final_report();
    end
endmodule : tb_top
